// File: core/sideband_params.svh
// Constants for the processor sideband control ends
// Summary of operation
// - Hold state floats all but acknowledges
// - hold_ack high exactly while in hold
// - Hold ignores all but few inputs
// - Enter hold from idle or cycle end, unlocked
// - Sample hold_request at phase one start
// - Master keeps hold_request synchronous to clock
// - Hold exit goes idle or first state
// - Reset ends hold; rehold before first cycle
// - Latch NMI edge during hold, service later
// - Keep executing from cache while granted
// - Coprocessor ports F8, FC, FE
// - External logic ends coprocessor cycles
// - Coprocessor inputs sampled at phase one
// - Sysmgmt interrupt outranks nonmaskable interrupt
// - System holds sysmgmt low four periods
// - Drive sysmgmt low four edges after sample
// - After return drive high two edges
// - System keeps released sysmgmt pin high
// - Sysmgmt strobe timed like address strobe
// - Trap needs sysmgmt three edges before done
// - Trapped I/O enters handler immediately
// - No trapping on coprocessor port accesses
`ifndef SIDEBAND_PARAMS_SVH
`define SIDEBAND_PARAMS_SVH
`define COPRO_CTRL_PORT  24'h8000F8
`define COPRO_OPND0_PORT 24'h8000FC
`define COPRO_OPND1_PORT 24'h8000FE
`define SMI_DRIVE_DELAY  3'h4
`define SMI_RELEASE_HIGH 3'h2
`define SMI_MIN_LOW      3'h4
`define NMI_VECTOR       8'h02
`define ADDR_W           24
`endif

// File: core/sideband_pkg.sv
// Types for the processor sideband end state machines
package sideband_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'h0,
    BUS_FIRST = 3'h1,
    BUS_CYCLE = 3'h2,
    BUS_HOLD  = 3'h3
  } bus_state_t;
  typedef enum logic [1:0] {
    SMI_IN    = 2'h0,
    SMI_WAIT  = 2'h1,
    SMI_LOW   = 2'h2,
    SMI_HIGH  = 2'h3
  } smi_state_t;
endpackage

// File: core/sideband_if.sv
// Pins between processor sideband logic and system logic
`timescale 1ns/100ps
interface sideband_if;
  logic        hold_request;
  logic        hold_ack;
  logic        bus_float_n;
  logic        addr_strobe_n;
  logic        sysmgmt_addr_strobe_n;
  logic [23:0] addr;
  logic        io_cycle;
  logic        cycle_done_n;
  logic        atomic_seq_n;
  logic        nonmaskable_irq;
  logic        copro_active_n;
  logic        copro_fault_n;
  logic        copro_operand_req;
  logic        smi_dev_out;
  logic        smi_dev_oe_n;
  logic        smi_sys_out;
  logic        smi_sys_oe_n;
  logic        sysmgmt_irq_n;
  assign sysmgmt_irq_n = !smi_dev_oe_n ? smi_dev_out : (!smi_sys_oe_n ? smi_sys_out : 1'b1);
  modport cpu (input hold_request, cycle_done_n, nonmaskable_irq, copro_active_n,
               copro_fault_n, copro_operand_req, sysmgmt_irq_n,
               output hold_ack, bus_float_n, addr_strobe_n, sysmgmt_addr_strobe_n, addr,
               io_cycle, atomic_seq_n, smi_dev_out, smi_dev_oe_n);
  modport sys (input hold_ack, bus_float_n, addr_strobe_n, sysmgmt_addr_strobe_n, addr,
               io_cycle, atomic_seq_n, sysmgmt_irq_n,
               output hold_request, cycle_done_n, nonmaskable_irq, copro_active_n,
               copro_fault_n, copro_operand_req, smi_sys_out, smi_sys_oe_n);
endinterface

// File: core/cpu_sideband.sv
// Processor end: hold arbitration, coprocessor sampling, sysmgmt handshake
`timescale 1ns/100ps
`include "sideband_params.svh"
module cpu_sideband (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  resetn_in,
  // Link
  sideband_if.cpu                    link,
  // Core requests
  input  wire logic                  bus_req_in,
  input  wire logic [23:0]           bus_addr_in,
  input  wire logic                  bus_io_in,
  input  wire logic                  bus_smm_in,
  input  wire logic                  bus_lock_in,
  input  wire logic                  cache_hit_in,
  input  wire logic                  rsm_in,
  input  wire logic                  nmi_ack_in,
  // Status to core
  output logic                       bus_done_out,
  output logic                       stall_out,
  output logic                       nmi_pending_out,
  output logic                       smi_take_out,
  output logic                       copro_active_out,
  output logic                       copro_fault_out,
  output logic                       copro_req_out
);
  import sideband_pkg::*;
  bus_state_t  bus_ff;
  smi_state_t  smi_ff;
  logic        phase_ff;
  logic [1:0]  hold_sync_ff, nmi_sync_ff, smi_sync_ff;
  logic [1:0]  act_sync_ff, flt_sync_ff, req_sync_ff, done_sync_ff;
  logic        nmi_prev_ff, in_hold, cyc_end;
  logic [2:0]  smi_cnt_ff;
  logic        trap_ff, copro_cyc_ff;
  logic [23:0] addr_ff;
  logic        io_ff;

  assign in_hold = (bus_ff == BUS_HOLD);

  // Current cycle finishes on this phase-one edge
  assign cyc_end = (bus_ff == BUS_CYCLE) && !phase_ff && !done_sync_ff[1];

  // Internal two-phase clock from the double-rate input
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) phase_ff <= 1'b0;
    else            phase_ff <= ~phase_ff;
  end

  // Pins from outside pass two flops
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_sync_ff <= 2'h0;
      nmi_sync_ff  <= 2'h0;
      smi_sync_ff  <= 2'h3;
      act_sync_ff  <= 2'h3;
      flt_sync_ff  <= 2'h3;
      req_sync_ff  <= 2'h0;
      done_sync_ff <= 2'h3;
    end else begin
      hold_sync_ff <= {hold_sync_ff[0], link.hold_request};
      nmi_sync_ff  <= {nmi_sync_ff[0], link.nonmaskable_irq};
      smi_sync_ff  <= {smi_sync_ff[0], link.sysmgmt_irq_n};
      act_sync_ff  <= {act_sync_ff[0], link.copro_active_n};
      flt_sync_ff  <= {flt_sync_ff[0], link.copro_fault_n};
      req_sync_ff  <= {req_sync_ff[0], link.copro_operand_req};
      done_sync_ff <= {done_sync_ff[0], link.cycle_done_n};
    end
  end

  // Coprocessor status taken at phase one only
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      copro_active_out <= 1'b0;
      copro_fault_out  <= 1'b0;
      copro_req_out    <= 1'b0;
    end else if (!phase_ff && !in_hold) begin
      copro_active_out <= ~act_sync_ff[1];
      copro_fault_out  <= ~flt_sync_ff[1];
      copro_req_out    <= req_sync_ff[1];
    end
  end

  // Bus state machine; reset returns to idle, ending hold
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) bus_ff <= BUS_IDLE;
    else if (!phase_ff) begin
      unique case (bus_ff)
        BUS_IDLE:  if (hold_sync_ff[1]) bus_ff <= BUS_HOLD;
                   else if (bus_req_in && !cache_hit_in) bus_ff <= BUS_FIRST;
        BUS_FIRST: bus_ff <= BUS_CYCLE;
        BUS_CYCLE: if (!done_sync_ff[1])
                     bus_ff <= (hold_sync_ff[1] && !bus_lock_in) ? BUS_HOLD :
                               BUS_IDLE;
        BUS_HOLD:  if (!hold_sync_ff[1])
                     bus_ff <= (bus_req_in && !cache_hit_in) ? BUS_FIRST : BUS_IDLE;
      endcase
    end
  end

  // Latch address at start of cycle
  // Also taken in hold, as hold exit may go straight to the first state
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_ff      <= 24'h000000;
      io_ff        <= 1'b0;
      copro_cyc_ff <= 1'b0;
    end else if (!phase_ff && bus_req_in && (bus_ff == BUS_IDLE || bus_ff == BUS_HOLD)) begin
      addr_ff      <= bus_addr_in;
      io_ff        <= bus_io_in;
      copro_cyc_ff <= bus_io_in && (bus_addr_in == `COPRO_CTRL_PORT ||
                      bus_addr_in == `COPRO_OPND0_PORT || bus_addr_in == `COPRO_OPND1_PORT);
    end
  end

  // Pin drivers; floats in hold, strobes share timing
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link.hold_ack              <= 1'b0;
      link.bus_float_n           <= 1'b1;
      link.addr_strobe_n         <= 1'b1;
      link.sysmgmt_addr_strobe_n <= 1'b1;
      link.addr                  <= 24'h000000;
      link.io_cycle              <= 1'b0;
      link.atomic_seq_n          <= 1'b1;
      bus_done_out               <= 1'b0;
      stall_out                  <= 1'b0;
    end else begin
      link.hold_ack    <= in_hold;
      link.bus_float_n <= ~in_hold;
      // First state spans two edges; strobe only on its second half
      link.addr_strobe_n <= !(bus_ff == BUS_FIRST && phase_ff && (io_ff || !bus_smm_in));
      link.sysmgmt_addr_strobe_n <= !(bus_ff == BUS_FIRST && phase_ff &&
                                      bus_smm_in && !io_ff);
      link.addr        <= addr_ff;
      link.io_cycle    <= io_ff;
      link.atomic_seq_n <= ~(bus_lock_in && bus_ff != BUS_IDLE && !in_hold);
      bus_done_out     <= cyc_end;
      stall_out        <= in_hold && bus_req_in && !cache_hit_in;
    end
  end

  // NMI edge remembered, also across hold
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nmi_prev_ff     <= 1'b0;
      nmi_pending_out <= 1'b0;
    end else begin
      nmi_prev_ff <= nmi_sync_ff[1];
      if (nmi_sync_ff[1] && !nmi_prev_ff) nmi_pending_out <= 1'b1;
      else if (nmi_ack_in && !in_hold && !smi_take_out) nmi_pending_out <= 1'b0;
    end
  end

  // I/O trap flag: sysmgmt seen during a non-coprocessor I/O cycle
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trap_ff <= 1'b0;
    end else begin
      if (bus_ff == BUS_CYCLE && io_ff && !copro_cyc_ff && smi_ff != SMI_IN)
        trap_ff <= 1'b1;
      else if (bus_ff == BUS_IDLE || bus_ff == BUS_HOLD) trap_ff <= 1'b0;
    end
  end

  // Handler entry; a trapped I/O cycle is finished first, so that
  // no instruction slips in between the I/O access and the handler
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      smi_take_out <= 1'b0;
    end else begin
      smi_take_out <= 1'b0;
      if (smi_ff == SMI_WAIT && smi_cnt_ff == 3'h1) begin
        smi_take_out <= !(trap_ff && bus_ff == BUS_CYCLE) || cyc_end;
      end else if (smi_ff == SMI_LOW && trap_ff && cyc_end) begin
        smi_take_out <= 1'b1;
      end
    end
  end

  // Sysmgmt pin handshake
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      smi_ff            <= SMI_IN;
      smi_cnt_ff        <= 3'h0;
      link.smi_dev_out  <= 1'b1;
      link.smi_dev_oe_n <= 1'b1;
    end else begin
      unique case (smi_ff)
        SMI_IN: if (!phase_ff && !smi_sync_ff[1] && !in_hold) begin
          smi_ff     <= SMI_WAIT;
          smi_cnt_ff <= `SMI_DRIVE_DELAY;
        end
        SMI_WAIT: if (smi_cnt_ff == 3'h1) begin
          smi_ff            <= SMI_LOW;
          link.smi_dev_out  <= 1'b0;
          link.smi_dev_oe_n <= 1'b0;
        end else smi_cnt_ff <= smi_cnt_ff - 3'h1;
        SMI_LOW: begin
          if (rsm_in) begin
            smi_ff           <= SMI_HIGH;
            link.smi_dev_out <= 1'b1;
            smi_cnt_ff       <= `SMI_RELEASE_HIGH;
          end
        end
        SMI_HIGH: if (smi_cnt_ff == 3'h1) begin
          smi_ff            <= SMI_IN;
          link.smi_dev_oe_n <= 1'b1;
        end else smi_cnt_ff <= smi_cnt_ff - 3'h1;
      endcase
    end
  end
endmodule

// File: core/sys_sideband.sv
// System end: bus master hold request, cycle completion, sysmgmt request
`timescale 1ns/100ps
`include "sideband_params.svh"
module sys_sideband (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // Link
  sideband_if.sys         link,
  // User requests
  input  wire logic       want_bus_in,
  input  wire logic       smi_req_in,
  input  wire logic       trap_io_in,
  input  wire logic       nmi_in,
  input  wire logic       copro_busy_in,
  input  wire logic       copro_err_in,
  input  wire logic       copro_opreq_in,
  // Status
  output logic            bus_granted_out,
  output logic            smi_done_out
);
  import sideband_pkg::*;
  logic       in_cycle_ff;
  logic [2:0] smi_cnt_ff, wait_ff;
  logic [1:0] ack_sync_ff, ads_sync_ff, sysmgmt_addr_strobe_n_sync_ff, smi_sync_ff;
  logic       smi_prev_ff;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_sync_ff   <= 2'h0;
      ads_sync_ff   <= 2'h3;
      sysmgmt_addr_strobe_n_sync_ff <= 2'h3;
      smi_sync_ff   <= 2'h3;
    end else begin
      ack_sync_ff   <= {ack_sync_ff[0], link.hold_ack};
      ads_sync_ff   <= {ads_sync_ff[0], link.addr_strobe_n};
      sysmgmt_addr_strobe_n_sync_ff <= {sysmgmt_addr_strobe_n_sync_ff[0], link.sysmgmt_addr_strobe_n};
      smi_sync_ff   <= {smi_sync_ff[0], link.sysmgmt_irq_n};
    end
  end

  // Synchronous request levels on every clock edge
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link.hold_request      <= 1'b0;
      link.nonmaskable_irq   <= 1'b0;
      link.copro_active_n    <= 1'b1;
      link.copro_fault_n     <= 1'b1;
      link.copro_operand_req <= 1'b0;
      bus_granted_out        <= 1'b0;
    end else begin
      link.hold_request      <= want_bus_in;
      link.nonmaskable_irq   <= nmi_in;
      link.copro_active_n    <= ~copro_busy_in;
      link.copro_fault_n     <= ~copro_err_in;
      link.copro_operand_req <= copro_opreq_in;
      bus_granted_out        <= ack_sync_ff[1] && want_bus_in;
    end
  end

  // Ends each cycle after a short wait, so a trap lands early enough
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      in_cycle_ff       <= 1'b0;
      wait_ff           <= 3'h0;
      link.cycle_done_n <= 1'b1;
    end else begin
      link.cycle_done_n <= 1'b1;
      if (!in_cycle_ff && (!ads_sync_ff[1] || !sysmgmt_addr_strobe_n_sync_ff[1])) begin
        in_cycle_ff <= 1'b1;
        wait_ff     <= 3'h4;
      end else if (in_cycle_ff) begin
        if (wait_ff == 3'h0) begin
          link.cycle_done_n <= 1'b0;
          in_cycle_ff       <= 1'b0;
        end else wait_ff <= wait_ff - 3'h1;
      end
    end
  end

  // Sysmgmt pin: drive low at least four periods, then release high
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      smi_cnt_ff        <= 3'h0;
      link.smi_sys_out  <= 1'b1;
      link.smi_sys_oe_n <= 1'b1;
      smi_prev_ff       <= 1'b1;
      smi_done_out      <= 1'b0;
    end else begin
      smi_prev_ff  <= smi_sync_ff[1];
      smi_done_out <= smi_sync_ff[1] && !smi_prev_ff && link.smi_sys_oe_n;
      if (smi_cnt_ff != 3'h0) begin
        smi_cnt_ff <= smi_cnt_ff - 3'h1;
        if (smi_cnt_ff == 3'h1) begin
          link.smi_sys_oe_n <= 1'b1;
          link.smi_sys_out  <= 1'b1;
        end
      end else if (smi_req_in || (trap_io_in && in_cycle_ff)) begin
        link.smi_sys_out  <= 1'b0;
        link.smi_sys_oe_n <= 1'b0;
        smi_cnt_ff        <= `SMI_MIN_LOW + 3'h2;
      end
    end
  end
endmodule

// File: tb/sideband_chk.sv
// Concurrent checks on the link between processor and system ends
`timescale 1ns/100ps
module sideband_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Link signals
  input wire logic hold_request,
  input wire logic hold_ack,
  input wire logic bus_float_n,
  input wire logic addr_strobe_n,
  input wire logic sysmgmt_addr_strobe_n,
  input wire logic atomic_seq_n,
  input wire logic smi_dev_out,
  input wire logic smi_dev_oe_n,
  input wire logic sysmgmt_irq_n
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence smi_drive_high;
    !smi_dev_oe_n && smi_dev_out;
  endsequence
  sequence smi_released;
    smi_dev_oe_n;
  endsequence
  a_hold_floats: assert property (hold_ack |-> !bus_float_n && addr_strobe_n && sysmgmt_addr_strobe_n)
    else $error("strobe or drive seen while bus granted");
  a_hold_rise: assert property ($rose(hold_ack) |-> $past(hold_request, 2))
    else $error("hold granted without request");
  a_hold_fall: assert property ($fell(hold_ack) |-> !$past(hold_request, 2))
    else $error("hold dropped while still requested");
  a_lock_blocks: assert property ($rose(hold_ack) |-> $past(atomic_seq_n))
    else $error("hold granted inside locked sequence");
  a_strobe_pulse: assert property (!addr_strobe_n |=> addr_strobe_n && sysmgmt_addr_strobe_n)
    else $error("address strobe longer than one cycle");
  a_sm_strobe: assert property (!sysmgmt_addr_strobe_n |-> addr_strobe_n ##1 sysmgmt_addr_strobe_n)
    else $error("sysmgmt strobe not shaped like address strobe");
  a_smi_delay: assert property ($fell(smi_dev_oe_n) |-> !smi_dev_out && !$past(sysmgmt_irq_n, 5))
    else $error("sysmgmt pin drive started at wrong time");
  a_smi_stays: assert property (!smi_dev_oe_n && !smi_dev_out |=> !smi_dev_oe_n)
    else $error("sysmgmt pin released while low");
  a_smi_high_two: assert property ($rose(smi_dev_out) && !smi_dev_oe_n |-> smi_drive_high [*2] ##1 smi_released)
    else $error("sysmgmt pin not high for two edges");
  a_smi_release: assert property ($rose(smi_dev_oe_n) |-> $past(smi_dev_out))
    else $error("sysmgmt pin released without high phase");
endmodule

// File: tb/test_cpu_bus_sideband_control.sv
// Self-checking bench joining processor and system sideband ends
`timescale 1ns/100ps
`include "sideband_params.svh"
module test_cpu_bus_sideband_control;
  localparam int HOLD = 0, STALL = 1, TAKE = 2, SMI_DONE = 3;
  logic        mclk_in, resetn_in, bus_req_in, bus_io_in, bus_smm_in, bus_lock_in;
  logic        cache_hit_in, rsm_in, nmi_ack_in, want_bus_in, smi_req_in, trap_io_in, nmi_in;
  logic [23:0] bus_addr_in;
  logic [2:0]  copro_in, copro_out;
  logic        bus_done_out, stall_out, nmi_pending_out, smi_take_out, bus_granted_out;
  logic        smi_done_out, hit;
  logic [24:0] exp_q[$];
  logic [24:0] tmp;
  int          n_errors, checks_done, i;
  int          seed = 32'h90FCCBE3;
  sideband_if sb ();
  cpu_sideband u_cpu_sideband (.mclk_in(mclk_in), .resetn_in(resetn_in), .link(sb.cpu),
    .bus_req_in(bus_req_in), .bus_addr_in(bus_addr_in), .bus_io_in(bus_io_in),
    .bus_smm_in(bus_smm_in), .bus_lock_in(bus_lock_in), .cache_hit_in(cache_hit_in),
    .rsm_in(rsm_in), .nmi_ack_in(nmi_ack_in), .bus_done_out(bus_done_out),
    .stall_out(stall_out), .nmi_pending_out(nmi_pending_out), .smi_take_out(smi_take_out),
    .copro_active_out(copro_out[2]), .copro_fault_out(copro_out[1]),
    .copro_req_out(copro_out[0]));
  sys_sideband u_sys_sideband (.mclk_in(mclk_in), .resetn_in(resetn_in), .link(sb.sys),
    .want_bus_in(want_bus_in), .smi_req_in(smi_req_in), .trap_io_in(trap_io_in),
    .nmi_in(nmi_in), .copro_busy_in(copro_in[2]), .copro_err_in(copro_in[1]),
    .copro_opreq_in(copro_in[0]), .bus_granted_out(bus_granted_out),
    .smi_done_out(smi_done_out));
  sideband_chk u_sideband_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .hold_request(sb.hold_request), .hold_ack(sb.hold_ack), .bus_float_n(sb.bus_float_n),
    .addr_strobe_n(sb.addr_strobe_n), .sysmgmt_addr_strobe_n(sb.sysmgmt_addr_strobe_n),
    .atomic_seq_n(sb.atomic_seq_n), .smi_dev_out(sb.smi_dev_out),
    .smi_dev_oe_n(sb.smi_dev_oe_n), .sysmgmt_irq_n(sb.sysmgmt_irq_n));
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic chk(input string nm, input logic [24:0] exp, input logic [24:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic flag(input int k);
    case (k)
      HOLD:     return sb.hold_ack;
      STALL:    return stall_out;
      TAKE:     return smi_take_out;
      SMI_DONE: return smi_done_out;
      default:  return bus_done_out;
    endcase
  endfunction
  // Flags are read at the edge, so a one-cycle pulse is never missed
  task automatic wait_for(input int k, input logic v, input int lim, output logic ok);
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (flag(k) !== v && n < lim);
    ok = (flag(k) === v);
  endtask
  task automatic bus_start(input logic [23:0] a, input logic io, smm, lock);
    @(posedge mclk_in);
    exp_q.push_back({smm, a});
    bus_addr_in <= a;
    bus_io_in <= io;
    bus_smm_in <= smm;
    bus_lock_in <= lock;
    bus_req_in <= 1'b1;
  endtask
  task automatic bus_wait;
    logic ok;
    wait_for(4, 1'b1, 80, ok);
    bus_req_in <= 1'b0;
    bus_lock_in <= 1'b0;
    chk("bus_done", 1, ok);
  endtask
  task automatic smi_round;
    logic ok;
    wait_for(TAKE, 1'b1, 60, ok);
    chk("smi_take", 1, ok);
    chk("smi_drive", 0, {sb.smi_dev_oe_n, sb.sysmgmt_irq_n});
    repeat (3) @(posedge mclk_in);
    rsm_in <= 1'b1;
    @(posedge mclk_in);
    rsm_in <= 1'b0;
    wait_for(SMI_DONE, 1'b1, 30, ok);
    chk("smi_done", 1, ok);
    repeat (2) @(posedge mclk_in);
    chk("smi_release", 3, {sb.smi_dev_oe_n, sb.sysmgmt_irq_n});
  endtask
  // Strobes may only appear for cycles the driver announced
  always @(posedge mclk_in) begin
    if (resetn_in && (sb.addr_strobe_n === 1'b0 || sb.sysmgmt_addr_strobe_n === 1'b0)) begin
      tmp = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1FFFFFF;
      chk("strobe_addr", tmp, {!sb.sysmgmt_addr_strobe_n, sb.addr});
    end
  end
  initial begin
    #100000;
    n_errors++;
    stop_test;
  end
  initial begin
    {resetn_in, bus_req_in, bus_io_in, bus_smm_in, bus_lock_in, cache_hit_in} = '0;
    {rsm_in, nmi_ack_in, want_bus_in, smi_req_in, trap_io_in, nmi_in, copro_in} = '0;
    bus_addr_in = '0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    for (i = 0; i < 6; i++) begin
      bus_start(24'($random(seed)), i % 3 == 1, i % 3 == 2, i == 3);
      bus_wait;
    end
    for (i = 0; i < 3; i++) begin
      bus_start(i == 0 ? `COPRO_CTRL_PORT : i == 1 ? `COPRO_OPND0_PORT : `COPRO_OPND1_PORT,
        1'b1, 1'b0, 1'b0);
      bus_wait;
    end
    repeat (4) begin
      copro_in <= 3'($random(seed));
      repeat (8) @(posedge mclk_in);
      chk("copro", copro_in, copro_out);
    end
    want_bus_in <= 1'b1;
    wait_for(HOLD, 1'b1, 40, hit);
    chk("hold_ack", 1, hit);
    repeat (3) @(posedge mclk_in);
    chk("float", 1, {sb.bus_float_n, bus_granted_out});
    cache_hit_in <= 1'b1;
    bus_start({8'h00, 16'($random(seed))}, 1'b0, 1'b0, 1'b0);
    nmi_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    nmi_in <= 1'b0;
    chk("stall_hit", 0, stall_out);
    chk("nmi_pend", 1, nmi_pending_out);
    cache_hit_in <= 1'b0;
    wait_for(STALL, 1'b1, 10, hit);
    chk("stall_miss", 1, hit);
    want_bus_in <= 1'b0;
    wait_for(HOLD, 1'b0, 40, hit);
    chk("hold_exit", 1, hit);
    bus_wait;
    nmi_ack_in <= 1'b1;
    @(posedge mclk_in);
    nmi_ack_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk("nmi_clear", 0, nmi_pending_out);
    smi_req_in <= 1'b1;
    @(posedge mclk_in);
    smi_req_in <= 1'b0;
    smi_round;
    trap_io_in <= 1'b1;
    bus_start({8'h00, 16'($random(seed))}, 1'b1, 1'b0, 1'b0);
    fork
      bus_wait;
      smi_round;
    join
    trap_io_in <= 1'b0;
    want_bus_in <= 1'b1;
    wait_for(HOLD, 1'b1, 40, hit);
    chk("hold_again", 1, hit);
    resetn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk("hold_reset", 0, sb.hold_ack);
    resetn_in <= 1'b1;
    wait_for(HOLD, 1'b1, 40, hit);
    chk("rehold", 1, hit);
    want_bus_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    chk("queue_left", 0, 25'(exp_q.size()));
    stop_test;
  end
endmodule
